// ---- common/asprdy_regs.vh ----
/*
 holds the constants of the serial port and ready logic.
 assumes inclusion by bare name from the design files.
*/
`ifndef ASPRDY_REGS_VH
`define ASPRDY_REGS_VH
`define ASPRDY_WORD_W 24
`define ASPRDY_CMD_W 8
`define ASPRDY_SEL_W 4
`define ASPRDY_SEL_DATA 4'h4
`define ASPRDY_SEL_MODE 4'h1
`define ASPRDY_SEL_CTRL 4'h2
`define ASPRDY_SEL_IO 4'h3
`define ASPRDY_SEL_CAL 4'h5
`define ASPRDY_CMD_READ_BIT 6
`define ASPRDY_MODE_W 3
`define ASPRDY_MODE_IDLE 3'h0
`define ASPRDY_MODE_CONV 3'h2
`define ASPRDY_MODE_CAL 3'h4
`define ASPRDY_CTRL_RESET 24'h000000
`define ASPRDY_CAL_RESET 24'h800000
`define ASPRDY_IO_RESET 24'h000000
`define ASPRDY_IO_DIR1_BIT 5
`define ASPRDY_IO_DIR2_BIT 4
`define ASPRDY_IO_DAT1_BIT 1
`define ASPRDY_IO_DAT2_BIT 0
`endif

// ---- hw/asprdy_sync.v ----
/*
 two-flop synchroniser for a bus of pin inputs.
 assumes inputs are asynchronous to sys_clk_in.
*/
`timescale 1ns/10ps
module asprdy_sync #(
   parameter W = 1
) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
reg [W-1:0] meta;
always @(posedge sys_clk_in)
begin
   if (!rst_n_in)
   begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
   end
   else if (ce_in)
   begin
      meta <= async_in;
      sync_out <= meta;
   end
end
endmodule

// ---- hw/asprdy_top.v ----
/*
 serial host port with data-ready output and two general-purpose bits.
 assumes converter core supplies result and calibration-done pulses on sys_clk_in.
*/
// Function
// - ready output goes low while an unread valid result sits in data register.
// - ready output returns high after host completes a data register read.
// - unread result: ready goes high before the next data register update.
// - ready output goes low when a calibration cycle finishes, unless a data register read completes in that cycle.
// - after calibration ready stays low until mode bits are written.
// - select is active low; serial traffic is ignored while select is high.
// - select going high ends a frame and resets bit alignment.
// - with select tied low the port still works three-wire.
// - continuous or burst serial clock keeps bit alignment.
// - output shift register loads from data, calibration, control, mode or io register.
// - input shift register transfers to register chosen by selection bits.
// - reset returns all registers and interface state to power-on values.
// - two general-purpose bits each configurable as input or output.
`timescale 1ns/10ps
`include "asprdy_regs.vh"
module asprdy_top #(
   parameter WORD_W = `ASPRDY_WORD_W,
   parameter UPD_LEAD = 2
) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire sclk_in,
   input wire cs_n_in,
   input wire din_in,
   input wire reset_n_pin_in,
   input wire [WORD_W-1:0] result_in,
   input wire result_valid_in,
   input wire update_soon_in,
   input wire cal_done_in,
   input wire gpio_bit_one_in,
   input wire gpio_bit_two_in,
   output reg dout_out,
   output reg rdy_n_out,
   output reg gpio_bit_one_out,
   output reg gpio_bit_one_oe_out,
   output reg gpio_bit_two_out,
   output reg gpio_bit_two_oe_out,
   output reg [`ASPRDY_MODE_W-1:0] mode_out,
   output reg mode_wr_out,
   output reg [WORD_W-1:0] ctrl_out,
   output reg [WORD_W-1:0] cal_out
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_CMD = 1'b0;
localparam ST_DAT = 1'b1;
localparam CW = `ASPRDY_CMD_W;
function [5:0] bits_for;
   input [`ASPRDY_SEL_W-1:0] sel;
   begin
      case (sel)
         `ASPRDY_SEL_MODE: bits_for = 6'h08;
         `ASPRDY_SEL_IO: bits_for = 6'h08;
         default: bits_for = WORD_W[5:0];
      endcase
   end
endfunction
wire [4:0] s;
asprdy_sync #(.W(5)) u_sync (
   .sys_clk_in(sys_clk_in),
   .rst_n_in(rst_n_in),
   .ce_in(ce_in),
   .async_in({~sclk_in, ~cs_n_in, din_in, gpio_bit_one_in, gpio_bit_two_in}),
   .sync_out(s)
);
// idle-high pins pass inverted, so the sync reset level reads as idle
wire sclk_s = !s[4];
wire cs_n_s = !s[3];
wire din_s = s[2];
reg rst_pin_m;
reg rst_pin_s;
reg sclk_d;
reg state;
reg rd;
reg [`ASPRDY_SEL_W-1:0] sel;
reg [5:0] cnt;
reg [WORD_W-1:0] ish;
reg [WORD_W-1:0] osh;
reg [WORD_W-1:0] data_reg;
reg [WORD_W-1:0] io_reg;
reg cal_hold;
reg [WORD_W-1:0] next_word;
wire rst_all = !rst_n_in || !rst_pin_s;
wire rise = sclk_s && !sclk_d;
wire fall = !sclk_s && sclk_d;
wire sel_act = !cs_n_s;
wire [5:0] nbits = bits_for(sel);
always @*
begin
   next_word = {ish[WORD_W-2:0], din_s};
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk_in)
begin
   if (!rst_n_in)
   begin
      rst_pin_m <= 1'b1;
      rst_pin_s <= 1'b1;
   end
   else if (ce_in)
   begin
      rst_pin_m <= reset_n_pin_in;
      rst_pin_s <= rst_pin_m;
   end
end
////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk_in)
begin
   if (rst_all)
   begin
      sclk_d <= 1'b1;
      state <= ST_CMD;
      rd <= 1'b0;
      sel <= {`ASPRDY_SEL_W{1'b0}};
      cnt <= 6'h00;
      ish <= {WORD_W{1'b0}};
      osh <= {WORD_W{1'b0}};
      dout_out <= 1'b0;
      rdy_n_out <= 1'b1;
      data_reg <= {WORD_W{1'b0}};
      io_reg <= `ASPRDY_IO_RESET;
      cal_hold <= 1'b0;
      mode_out <= `ASPRDY_MODE_IDLE;
      mode_wr_out <= 1'b0;
      ctrl_out <= `ASPRDY_CTRL_RESET;
      cal_out <= `ASPRDY_CAL_RESET;
      gpio_bit_one_out <= 1'b0;
      gpio_bit_one_oe_out <= 1'b0;
      gpio_bit_two_out <= 1'b0;
      gpio_bit_two_oe_out <= 1'b0;
   end
   else if (ce_in)
   begin
      sclk_d <= sclk_s;
      mode_wr_out <= 1'b0;
      gpio_bit_one_oe_out <= io_reg[`ASPRDY_IO_DIR1_BIT];
      gpio_bit_two_oe_out <= io_reg[`ASPRDY_IO_DIR2_BIT];
      gpio_bit_one_out <= io_reg[`ASPRDY_IO_DAT1_BIT];
      gpio_bit_two_out <= io_reg[`ASPRDY_IO_DAT2_BIT];
      if (update_soon_in && !cal_hold)
         rdy_n_out <= 1'b1;
      if (result_valid_in && !cal_hold)
      begin
         data_reg <= result_in;
         rdy_n_out <= 1'b0;
      end
      if (cal_done_in)
      begin
         cal_hold <= 1'b1;
         rdy_n_out <= 1'b0;
      end
      if (io_reg[`ASPRDY_IO_DIR1_BIT] == 1'b0)
         io_reg[`ASPRDY_IO_DAT1_BIT] <= s[1];
      if (io_reg[`ASPRDY_IO_DIR2_BIT] == 1'b0)
         io_reg[`ASPRDY_IO_DAT2_BIT] <= s[0];
      if (!sel_act)
      begin
         state <= ST_CMD;
         cnt <= 6'h00;
      end
      // select tied low never resets alignment
      // bits counted only on clock edges
      else if (rise)
      begin
         ish <= next_word;
         if (state == ST_CMD)
         begin
            if (cnt == CW - 1)
            begin
               cnt <= 6'h00;
               rd <= next_word[`ASPRDY_CMD_READ_BIT];
               sel <= next_word[`ASPRDY_SEL_W-1:0];
               state <= ST_DAT;
               case (next_word[`ASPRDY_SEL_W-1:0])
                  `ASPRDY_SEL_DATA: osh <= data_reg;
                  `ASPRDY_SEL_CAL: osh <= cal_out;
                  `ASPRDY_SEL_CTRL: osh <= ctrl_out;
                  `ASPRDY_SEL_MODE: osh <= {mode_out, {(WORD_W-3){1'b0}}};
                  `ASPRDY_SEL_IO: osh <= {io_reg[7:0], {(WORD_W-8){1'b0}}};
                  default: osh <= {WORD_W{1'b0}};
               endcase
            end
            else
               cnt <= cnt + 6'h01;
         end
         else if (cnt == nbits - 6'h01)
         begin
            cnt <= 6'h00;
            state <= ST_CMD;
            if (rd)
            begin
               if (sel == `ASPRDY_SEL_DATA && !cal_hold && !result_valid_in)
                  rdy_n_out <= 1'b1;
            end
            else
            begin
               case (sel)
                  `ASPRDY_SEL_CTRL: ctrl_out <= next_word;
                  `ASPRDY_SEL_CAL: cal_out <= next_word;
                  `ASPRDY_SEL_IO: io_reg <= {{(WORD_W-8){1'b0}}, next_word[7:0]};
                  `ASPRDY_SEL_MODE:
                  begin
                     mode_out <= next_word[2:0];
                     mode_wr_out <= 1'b1;
                     if (!cal_done_in)
                     begin
                        cal_hold <= 1'b0;
                        rdy_n_out <= 1'b1;
                     end
                  end
                  default: ctrl_out <= ctrl_out;
               endcase
            end
         end
         else
            cnt <= cnt + 6'h01;
      end
      // drive on falling edge msb first
      if (sel_act && fall && state == ST_DAT && rd)
      begin
         dout_out <= osh[WORD_W-1];
         osh <= {osh[WORD_W-2:0], 1'b0};
      end
   end
end
endmodule

// ---- bench/asprdy_top_chk.sv ----
/* checker for the ready output and frame rules.
 assumes binding to asprdy_top, ce_in held high. */
`timescale 1ns/10ps
module asprdy_top_chk #(parameter WORD_W = 24) (
   input wire sys_clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire cs_n_in,
   input wire sclk_in,
   input wire result_valid_in,
   input wire update_soon_in,
   input wire cal_done_in,
   input wire dout_out,
   input wire rdy_n_out,
   input wire mode_wr_out,
   input wire [WORD_W-1:0] ctrl_out,
   input wire [WORD_W-1:0] cal_out
);
   reg hold;
   always @(posedge sys_clk_in)
   begin
      if (!rst_n_in || mode_wr_out)
         hold <= 1'b0;
      else if (cal_done_in)
         hold <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   result_ready_a:
      assert property (result_valid_in |-> ##[1:3] !rdy_n_out) else $error("ready not set");
   stale_ready_a:
      assert property (update_soon_in && !hold |-> ##[1:3] rdy_n_out) else $error("ready stale");
   cal_ready_a:
      assert property (cal_done_in |-> ##[1:3] !rdy_n_out) else $error("cal ready late");
   cal_hold_a:
      assert property (hold && $past(hold) && !mode_wr_out |-> !rdy_n_out) else $error("hold lost");
   mode_release_a:
      assert property (mode_wr_out |-> ##[0:2] rdy_n_out) else $error("mode no release");
   deselect_quiet_a:
      assert property (cs_n_in [*8] |-> !mode_wr_out) else $error("write while deselected");
   reset_state_a:
      assert property (disable iff (1'b0) !rst_n_in && ce_in |=> rdy_n_out && !mode_wr_out
         && cal_out == 24'h800000 && ctrl_out == 24'h0) else $error("bad reset state");
   out_edge_a:
      assert property ($changed(dout_out) && !cs_n_in && !$past(cs_n_in, 4) |-> !sclk_in)
         else $error("dout moved on rise");
endmodule
bind asprdy_top asprdy_top_chk #(.WORD_W(WORD_W)) chk (.sys_clk_in, .rst_n_in, .ce_in,
   .cs_n_in, .sclk_in, .result_valid_in, .update_soon_in, .cal_done_in, .dout_out,
   .rdy_n_out, .mode_wr_out, .ctrl_out, .cal_out);

// ---- bench/asprdy_host.sv ----
/* host model: serial master with burst clock.
 assumes dout settles before the next rising sclk. */
`timescale 1ns/10ps
module asprdy_host (
   input wire sys_clk_in,
   input wire dout_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out
);
   // select stays low between frames when set
   logic three_wire = 1'b0;
   initial
   begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end
   task automatic xfer(input logic sel_n, input logic [31:0] w, input int n,
      output logic [23:0] r);
      int i;
      r = 24'h0;
      @(negedge sys_clk_in);
      cs_n_out = sel_n;
      for (i = n - 1; i >= 0; i--)
      begin
         repeat (4) @(negedge sys_clk_in);
         sclk_out = 1'b0;
         din_out = w[i];
         repeat (4) @(negedge sys_clk_in);
         sclk_out = 1'b1;
         r = {r[22:0], dout_in};
         if (i == n - 8)
            repeat (24) @(negedge sys_clk_in);
      end
      repeat (8) @(negedge sys_clk_in);
      if (!three_wire)
         cs_n_out = 1'b1;
      din_out = ~din_out;
      repeat (8) @(negedge sys_clk_in);
   endtask
endmodule

// ---- bench/tb_asprdy_top.sv ----
/* self-checking bench for the serial port.
 assumes a 10 MHz clock and the host model. */
`timescale 1ns/10ps
module tb_asprdy_top;
   logic sys_clk_in = 0, rst_n_in = 0, ce_in = 1, reset_n_pin_in = 1;
   logic result_valid_in = 0, update_soon_in = 0, cal_done_in = 0;
   logic gpio_bit_one_in = 1, gpio_bit_two_in = 0, sclk_in, cs_n_in, din_in;
   logic dout_out, rdy_n_out, mode_wr_out, gpio_bit_one_out, gpio_bit_one_oe_out;
   logic gpio_bit_two_out, gpio_bit_two_oe_out;
   logic [2:0] mode_out;
   logic [23:0] result_in = 24'h0, rd, ctrl_out, cal_out;
   int mismatches = 0, n_checks = 0, cyc = 0;
   asprdy_top dut (.sys_clk_in, .rst_n_in, .ce_in, .sclk_in, .cs_n_in, .din_in,
      .reset_n_pin_in, .result_in, .result_valid_in, .update_soon_in, .cal_done_in,
      .gpio_bit_one_in, .gpio_bit_two_in, .dout_out, .rdy_n_out, .gpio_bit_one_out,
      .gpio_bit_one_oe_out, .gpio_bit_two_out, .gpio_bit_two_oe_out, .mode_out,
      .mode_wr_out, .ctrl_out, .cal_out);
   asprdy_host host (.sys_clk_in, .dout_in(dout_out), .sclk_out(sclk_in),
      .cs_n_out(cs_n_in), .din_out(din_in));
   initial forever #50 sys_clk_in = ~sys_clk_in;
   ////////////////////////////////////////////////////////////
   task chk(string nm, logic [23:0] s, logic [23:0] e);
      n_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("ERROR %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge sys_clk_in) s = 1'b1;
      @(negedge sys_clk_in) s = 1'b0;
      repeat (5) @(negedge sys_clk_in);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task t_regs;
      chk("cal", cal_out, 24'h800000);
      host.xfer(1'b0, 32'h02a5c30f, 32, rd);
      chk("ctrl", ctrl_out, 24'ha5c30f);
      host.xfer(1'b1, 32'h02123456, 32, rd);
      chk("ctrl kept", ctrl_out, 24'ha5c30f);
      host.xfer(1'b0, 32'h42000000, 32, rd);
      chk("ctrl read", rd, 24'ha5c30f);
      $display("regs done");
   endtask
   task t_ready;
      result_in = 24'h5a3c96;
      pulse(result_valid_in);
      chk("rdy set", rdy_n_out, 24'h0);
      host.xfer(1'b0, 32'h44000000, 32, rd);
      chk("data", rd, 24'h5a3c96);
      chk("rdy read", rdy_n_out, 24'h1);
      pulse(result_valid_in);
      pulse(update_soon_in);
      chk("rdy stale", rdy_n_out, 24'h1);
      $display("ready done");
   endtask
   task t_cal;
      pulse(cal_done_in);
      chk("rdy cal", rdy_n_out, 24'h0);
      pulse(update_soon_in);
      chk("rdy hold", rdy_n_out, 24'h0);
      host.xfer(1'b0, 32'h0102, 16, rd);
      chk("mode", mode_out, 24'h2);
      chk("rdy mode", rdy_n_out, 24'h1);
      $display("cal done");
   endtask
   task t_io;
      host.xfer(1'b0, 32'h4300, 16, rd);
      chk("io in", rd[7:0], 24'h02);
      host.xfer(1'b0, 32'h0332, 16, rd);
      chk("io", {gpio_bit_one_oe_out, gpio_bit_one_out, gpio_bit_two_oe_out,
         gpio_bit_two_out}, 24'he);
      $display("io done");
   endtask
   task t_pin;
      host.three_wire = 1'b1;
      host.xfer(1'b0, 32'h02123456, 32, rd);
      host.xfer(1'b0, 32'h42000000, 32, rd);
      chk("wire3 ctrl", rd, 24'h123456);
      reset_n_pin_in = 1'b0;
      repeat (5) @(negedge sys_clk_in);
      chk("pin ctrl", ctrl_out, 24'h0);
      chk("pin mode", mode_out, 24'h0);
      reset_n_pin_in = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      host.three_wire = 1'b0;
      host.xfer(1'b0, 32'h02654321, 32, rd);
      chk("pin after", ctrl_out, 24'h654321);
      $display("pin done");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      reset_n_pin_in = 1'b0;
      repeat (5) @(negedge sys_clk_in);
      rst_n_in = 1'b1;
      reset_n_pin_in = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      t_regs;
      t_ready;
      t_cal;
      t_io;
      t_pin;
      stop_test;
   end
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         mismatches++;
         stop_test;
      end
   end
endmodule
